//--- dv/tb_top.sv
// self-checking bench for the usb global control block
`timescale 1ns/1ps
`default_nettype none
module tb_top import ugc_pkg::*; ();
	logic       ref_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sof_req = 1'b0, rd_d = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
	logic       bus_dp, bus_dm, sof_ok, function_on, configured_flag, resume_drive, usb_irq;
	logic [6:0] active_address;
	logic [1:0] endpoint_select_field, line_cmd = 2'h0;
	logic [7:0] exp_q[$];
	int         n_mismatch = 0, cmp_count = 0, i, seed = 32'h0b51;
	ugc_global_ctrl #(.SUSPEND_CYC(50), .SUSP_MIN_CYC(60), .RESUME_CYC(20)) ugc_global_ctrl_inst (.ref_clk, .rst_n,
		.sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .bus_dp, .bus_dm, .sof_ok, .active_address,
		.function_on, .configured_flag, .endpoint_select_field, .resume_drive, .usb_irq);
	ugc_usb_host ugc_usb_host_inst (.ref_clk, .line_cmd, .sof_req, .resume_drive, .bus_dp, .bus_dm, .sof_ok);
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tk
	task wr(input logic [7:0] a, input logic [7:0] d);
		tk(1);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tk(1);
		sfr_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		tk(1);
		sfr_addr = a;
		sfr_rd = 1'b1;
		exp_q.push_back(e);
		tk(1);
		sfr_rd = 1'b0;
	endtask : rd
	task wt(input logic v);
		i = 0;
		while (resume_drive !== v && i < 200) begin
			tk(1);
			i++;
		end
		chk(8'(resume_drive), 8'(v));
	endtask : wt
	task final_report;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	// read results land one cycle after the read edge
	always @(posedge ref_clk) begin
		if (rd_d) chk(sfr_rdata, exp_q.pop_front());
		rd_d = sfr_rd;
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		final_report;
	end
	initial begin
		tk(20);
		rst_n = 1'b1;
		rd(UGC_ADDR_ENABLES, 8'h10);
		rd(UGC_ADDR_FUNCADDR, 8'h00);
		rd(UGC_ADDR_CONTROL, 8'h00);
		rd(8'h80, 8'h00);
		wr(UGC_ADDR_ENABLES, 8'h39);
		rd(UGC_ADDR_ENABLES, 8'h39);
		for (int k = 0; k < 4; k++) begin
			r = 8'($random(seed)) & 8'h03;
			wr(UGC_ADDR_EPSEL, r);
			rd(UGC_ADDR_EPSEL, r & 8'h03);
			chk(8'(endpoint_select_field), r & 8'h03);
		end
		wr(UGC_ADDR_FUNCADDR, 8'haa);
		chk(8'(active_address), 8'h00);
		rd(UGC_ADDR_FUNCADDR, 8'haa);
		wr(UGC_ADDR_FUNCADDR, 8'h00);
		rd(UGC_ADDR_FUNCADDR, 8'h80);
		wr(UGC_ADDR_FUNCADDR, 8'h85);
		wr(UGC_ADDR_CONTROL, 8'h03);
		tk(2);
		chk(8'(active_address), 8'h05);
		chk(8'(configured_flag), 8'h01);
		line_cmd = 2'h1;
		wr(UGC_ADDR_FLAGS, 8'h00);
		tk(600);
		line_cmd = 2'h0;
		tk(8);
		chk(8'(configured_flag), 8'h00);
		chk(8'(active_address), 8'h00);
		rd(UGC_ADDR_FLAGS, 8'h10);
		chk(8'(usb_irq), 8'h01);
		rd(UGC_ADDR_FUNCADDR, 8'h80);
		rd(UGC_ADDR_CONTROL, 8'h00);
		wr(UGC_ADDR_ENABLES, 8'h08);
		sof_req = 1'b1;
		tk(1);
		sof_req = 1'b0;
		tk(2);
		chk(8'(usb_irq), 8'h01);
		rd(UGC_ADDR_FLAGS, 8'h18);
		wr(UGC_ADDR_FLAGS, 8'h00);
		wr(UGC_ADDR_ENABLES, 8'h20);
		tk(70);
		rd(UGC_ADDR_FLAGS, 8'h01);
		chk(8'(usb_irq), 8'h00);
		line_cmd = 2'h2;
		tk(10);
		line_cmd = 2'h0;
		tk(8);
		rd(UGC_ADDR_FLAGS, 8'h21);
		chk(8'(usb_irq), 8'h01);
		wr(UGC_ADDR_FLAGS, 8'h00);
		wr(UGC_ADDR_ENABLES, 8'h00);
		tk(70);
		rd(UGC_ADDR_FLAGS, 8'h01);
		wr(UGC_ADDR_FLAGS, 8'h00);
		wr(UGC_ADDR_CONTROL, 8'h04);
		wr(UGC_ADDR_CONTROL, 8'h24);
		wt(1'b1);
		rd(UGC_ADDR_CONTROL, 8'h2c);
		wt(1'b0);
		rd(UGC_ADDR_CONTROL, 8'h24);
		rd(UGC_ADDR_FLAGS, 8'h00);
		tk(3);
		final_report;
	end
endmodule : tb_top
`default_nettype wire

//--- dv/ugc_global_ctrl_chk.sv
// port checker for the usb global control block
`timescale 1ns/1ps
`default_nettype none
module ugc_global_ctrl_chk
	import ugc_pkg::*;
#(
	parameter int RESUME_CYC = UGC_RESUME_CYC
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sof_ok,
	input wire logic [6:0] active_address,
	input wire logic       function_on,
	input wire logic [1:0] endpoint_select_field,
	input wire logic       resume_drive,
	input wire logic       usb_irq
);
	logic [7:0]           en_ff;
	logic [UGC_CNT_W-1:0] rs_len_ff;
	// length of the running resume drive in cycles
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rs_len_ff <= '0;
		end else if (resume_drive) begin
			rs_len_ff <= rs_len_ff + 1'b1;
		end else begin
			rs_len_ff <= '0;
		end
	end
	// shadow of the enable register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			en_ff <= UGC_ENABLES_RST;
		end else if (sfr_wr && sfr_addr == UGC_ADDR_ENABLES) begin
			en_ff <= sfr_wdata & UGC_FLG_MASK;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_rd_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read data not idle");
	chk_flag_rsvd: assert property ($past(sfr_rd && sfr_addr == UGC_ADDR_FLAGS) |->
		(sfr_rdata & ~UGC_FLG_MASK) == 8'h00) else $error("flag reserved bits set");
	chk_epsel_wr: assert property (sfr_wr && sfr_addr == UGC_ADDR_EPSEL |-> ##2
		endpoint_select_field == $past(sfr_wdata[1:0], 2)) else $error("endpoint select not taken");
	chk_en_read: assert property ($past(sfr_rd && sfr_addr == UGC_ADDR_ENABLES) |->
		sfr_rdata == $past(en_ff)) else $error("enable read wrong");
	chk_fon_hold: assert property (function_on |=> function_on)
		else $error("function on dropped");
	chk_addr_dflt: assert property ($past(sfr_rd && sfr_addr == UGC_ADDR_CONTROL) && !sfr_rdata[0] |->
		active_address == 7'h00) else $error("address not default");
	chk_resume_len: assert property ($fell(resume_drive) |-> rs_len_ff == UGC_CNT_W'(RESUME_CYC - 1))
		else $error("resume length wrong");
	chk_sof_irq: assert property (sof_ok && en_ff[UGC_FLG_FRAME_START] |-> ##2 usb_irq)
		else $error("frame start irq missing");
	chk_irq_hold: assert property ($fell(usb_irq) |-> $past(sfr_wr, 2))
		else $error("irq fell without clear");
	cover property ($rose(resume_drive));
	cover property ($fell(usb_irq));
	cover property (sof_ok);
endmodule : ugc_global_ctrl_chk
bind ugc_global_ctrl ugc_global_ctrl_chk #(.RESUME_CYC(RESUME_CYC)) ugc_global_ctrl_chk_inst (.ref_clk, .rst_n,
	.sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .sof_ok, .active_address, .function_on,
	.endpoint_select_field, .resume_drive, .usb_irq);
`default_nettype wire

//--- dv/ugc_usb_host.sv
// host side model: bus line states and sof pulses
`timescale 1ns/1ps
`default_nettype none
module ugc_usb_host (
	input  wire logic       ref_clk,
	input  wire logic [1:0] line_cmd,
	input  wire logic       sof_req,
	input  wire logic       resume_drive,
	output var  logic       bus_dp,
	output var  logic       bus_dm,
	output var  logic       sof_ok
);
	// 0 idle j, 1 se0 reset, 2 k signalling; device resume puts k on the bus
	always @(posedge ref_clk) begin
		bus_dp <= (line_cmd == 2'h0) && !resume_drive;
		bus_dm <= (line_cmd == 2'h2) || resume_drive;
		sof_ok <= sof_req;
	end
endmodule : ugc_usb_host
`default_nettype wire

//--- rtl/ugc_global_ctrl.sv
// usb device global control, function address, global flags, enables and endpoint select
// Overview of operation
// - reserved bits of control, flag, enable and select registers read zero.
// - resume-in-progress rises on wake request with wake allowed, once suspended and the bus idle J for the remote wake minimum; drops after resume ends.
// - configured clears on hardware reset and on bus reset (SE0 2.7 us).
// - address valid clears on resets; while clear, device answers at address zero.
// - function on clears at power-up; firmware sets it after bus reset.
// - device address field holds zero after power-up or bus reset.
// - bus wake flag sets on bus activity while suspended, not on own resume.
// - reset end flag sets at end of bus reset; interrupts when enabled.
// - frame start flag sets on each good SOF; interrupts when enabled.
// - suspend flag sets after 3 ms idle J state; interrupts when enabled.
// - separate enables gate wake, frame start and suspend interrupt requests.
// - reset end enable resets set, enable register resets to 0001 0000b.
// - two-bit endpoint select steers endpoint register accesses.
`timescale 1ns/1ps
`default_nettype none
module ugc_global_ctrl
	import ugc_pkg::*;
#(
	parameter int SUSPEND_CYC = UGC_SUSPEND_CYC,
	parameter int SUSP_MIN_CYC = UGC_SUSP_MIN_CYC,
	parameter int RESUME_CYC  = UGC_RESUME_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output var  logic [7:0] sfr_rdata,
	input  wire logic       bus_dp,
	input  wire logic       bus_dm,
	input  wire logic       sof_ok,
	output var  logic [6:0] active_address,
	output var  logic       function_on,
	output var  logic       configured_flag,
	output var  logic [1:0] endpoint_select_field,
	output var  logic       resume_drive,
	output var  logic       usb_irq
);
	typedef enum logic [1:0] {
		UGC_ACTIVE  = 2'b00,
		UGC_SUSPEND = 2'b01,
		UGC_RESUME  = 2'b11
	} ugc_state_t;

	ugc_state_t           state_ff;
	logic                 dp_s;
	logic                 dm_s;
	logic [UGC_CNT_W-1:0] se0_cnt_ff;
	logic [UGC_CNT_W-1:0] idle_cnt_ff;
	logic [UGC_CNT_W-1:0] rsm_cnt_ff;
	logic                 in_reset_ff;
	logic                 address_valid_flag_ff;
	logic                 remote_wake_allowed_ff;
	logic                 remote_wake_request_ff;
	logic [6:0]           device_address_field_ff;
	logic                 function_on_ff;
	logic [7:0]           flags_ff;
	logic [7:0]           enables_ff;
	logic [1:0]           epsel_ff;
	logic                 configured_ff;
	logic                 bus_se0;
	logic                 bus_idle_j;
	logic                 bus_reset_hit;
	logic                 reset_end;
	logic                 wr_ctl;
	logic                 wr_flg;
	logic                 wr_ena;
	logic                 wr_fa;
	logic                 wr_ep;
	logic [7:0]           ctl_view;
	logic [7:0]           nxt_flags;
	logic [7:0]           set_flags;

	// stages start at the idle j levels so no false se0 follows reset
	ugc_line_sync u_sync_dp (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.line_in  (bus_dp),
		.rst_val  (1'b1),
		.line_out (dp_s)
	);
	ugc_line_sync u_sync_dm (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.line_in  (bus_dm),
		.rst_val  (1'b0),
		.line_out (dm_s)
	);

	assign bus_se0    = !dp_s && !dm_s;
	assign bus_idle_j = dp_s && !dm_s;
	assign bus_reset_hit = (se0_cnt_ff == UGC_CNT_W'(UGC_BUS_RESET_CYC - 1)) && bus_se0;
	assign reset_end  = in_reset_ff && !bus_se0;

	assign wr_ctl = sfr_wr && (sfr_addr == UGC_ADDR_CONTROL);
	assign wr_flg = sfr_wr && (sfr_addr == UGC_ADDR_FLAGS);
	assign wr_ena = sfr_wr && (sfr_addr == UGC_ADDR_ENABLES);
	assign wr_fa  = sfr_wr && (sfr_addr == UGC_ADDR_FUNCADDR);
	assign wr_ep  = sfr_wr && (sfr_addr == UGC_ADDR_EPSEL);

	// bus line timers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			se0_cnt_ff  <= '0;
			in_reset_ff <= 1'b0;
		end else begin
			if (!bus_se0) begin
				se0_cnt_ff <= '0;
			end else if (se0_cnt_ff != UGC_CNT_W'(UGC_BUS_RESET_CYC)) begin
				se0_cnt_ff <= se0_cnt_ff + 1'b1;
			end
			if (bus_reset_hit) begin
				in_reset_ff <= 1'b1;
			end else if (!bus_se0) begin
				in_reset_ff <= 1'b0;
			end
		end
	end

	// idle j timer, runs on through suspend up to the remote wake minimum
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idle_cnt_ff <= '0;
		end else if (!bus_idle_j) begin
			idle_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				UGC_ACTIVE: begin
					if (idle_cnt_ff != UGC_CNT_W'(SUSPEND_CYC)) begin
						idle_cnt_ff <= idle_cnt_ff + 1'b1;
					end
				end
				UGC_SUSPEND: begin
					if (idle_cnt_ff != UGC_CNT_W'(SUSP_MIN_CYC)) begin
						idle_cnt_ff <= idle_cnt_ff + 1'b1;
					end
				end
				default: idle_cnt_ff <= '0;
			endcase
		end
	end

	// suspend and resume sequencing
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff   <= UGC_ACTIVE;
			rsm_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				UGC_ACTIVE: begin
					if (idle_cnt_ff == UGC_CNT_W'(SUSPEND_CYC - 1) && bus_idle_j) begin
						state_ff <= UGC_SUSPEND;
					end
				end
				UGC_SUSPEND: begin
					if (!bus_idle_j) begin
						state_ff <= UGC_ACTIVE;
					end else if (remote_wake_request_ff && remote_wake_allowed_ff
							&& idle_cnt_ff == UGC_CNT_W'(SUSP_MIN_CYC)) begin
						state_ff   <= UGC_RESUME;
						rsm_cnt_ff <= '0;
					end
				end
				UGC_RESUME: begin
					if (rsm_cnt_ff == UGC_CNT_W'(RESUME_CYC - 1)) begin
						state_ff <= UGC_ACTIVE;
					end else begin
						rsm_cnt_ff <= rsm_cnt_ff + 1'b1;
					end
				end
				default: state_ff <= UGC_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			resume_drive <= 1'b0;
		end else begin
			resume_drive <= (state_ff == UGC_RESUME) && (rsm_cnt_ff != UGC_CNT_W'(RESUME_CYC - 1));
		end
	end

	// global control bits
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			configured_ff          <= 1'b0;
			address_valid_flag_ff  <= 1'b0;
			remote_wake_allowed_ff <= 1'b0;
			remote_wake_request_ff <= 1'b0;
		end else if (bus_reset_hit) begin
			configured_ff          <= 1'b0;
			address_valid_flag_ff  <= 1'b0;
			remote_wake_allowed_ff <= 1'b0;
			remote_wake_request_ff <= 1'b0;
		end else if (wr_ctl) begin
			configured_ff          <= sfr_wdata[UGC_CTL_CONFIGURED];
			address_valid_flag_ff  <= sfr_wdata[UGC_CTL_ADDR_VALID];
			remote_wake_allowed_ff <= sfr_wdata[UGC_CTL_WAKE_ALLOW];
			remote_wake_request_ff <= sfr_wdata[UGC_CTL_WAKE_REQ];
		end
	end

	// function address
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			function_on_ff          <= UGC_FUNCADDR_RST[UGC_FA_FUNCTION_ON];
			device_address_field_ff <= UGC_FUNCADDR_RST[6:0];
		end else if (bus_reset_hit) begin
			device_address_field_ff <= UGC_FUNCADDR_RST[6:0];
		end else if (wr_fa) begin
			function_on_ff          <= function_on_ff | sfr_wdata[UGC_FA_FUNCTION_ON];
			device_address_field_ff <= sfr_wdata[6:0];
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always_comb begin
		set_flags = UGC_ZERO_RST;
		set_flags[UGC_FLG_BUS_WAKE]    = (state_ff == UGC_SUSPEND) && !bus_idle_j;
		set_flags[UGC_FLG_RESET_END]   = reset_end;
		set_flags[UGC_FLG_FRAME_START] = sof_ok;
		set_flags[UGC_FLG_SUSPEND]     = (state_ff == UGC_ACTIVE) && bus_idle_j
			&& (idle_cnt_ff == UGC_CNT_W'(SUSPEND_CYC - 1));
		nxt_flags = flags_ff;
		if (wr_flg) begin
			nxt_flags = flags_ff & sfr_wdata;
		end
		nxt_flags = (nxt_flags | set_flags) & UGC_FLG_MASK;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flags_ff <= UGC_ZERO_RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			enables_ff <= UGC_ENABLES_RST;
			epsel_ff   <= UGC_ZERO_RST[1:0];
		end else begin
			if (wr_ena) begin
				enables_ff <= sfr_wdata & UGC_FLG_MASK;
			end
			if (wr_ep) begin
				epsel_ff <= sfr_wdata[1:0];
			end
		end
	end

	always_comb begin
		ctl_view = UGC_ZERO_RST;
		ctl_view[UGC_CTL_WAKE_REQ]    = remote_wake_request_ff;
		ctl_view[UGC_CTL_RESUME_PROG] = (state_ff == UGC_RESUME);
		ctl_view[UGC_CTL_WAKE_ALLOW]  = remote_wake_allowed_ff;
		ctl_view[UGC_CTL_CONFIGURED]  = configured_ff;
		ctl_view[UGC_CTL_ADDR_VALID]  = address_valid_flag_ff;
	end

	// read data stands one cycle, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sfr_rdata <= UGC_ZERO_RST;
		end else begin
			sfr_rdata <= UGC_ZERO_RST;
			if (sfr_rd) begin
				unique case (sfr_addr)
					UGC_ADDR_CONTROL:  sfr_rdata <= ctl_view;
					UGC_ADDR_FLAGS:    sfr_rdata <= flags_ff;
					UGC_ADDR_ENABLES:  sfr_rdata <= enables_ff;
					UGC_ADDR_FUNCADDR: sfr_rdata <= {function_on_ff, device_address_field_ff};
					UGC_ADDR_EPSEL:    sfr_rdata <= {6'b00_0000, epsel_ff};
					default:           sfr_rdata <= UGC_ZERO_RST;
				endcase
			end
		end
	end

	// registered status outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			active_address        <= 7'h00;
			function_on           <= 1'b0;
			configured_flag       <= 1'b0;
			endpoint_select_field <= 2'b00;
			usb_irq               <= 1'b0;
		end else begin
			active_address        <= address_valid_flag_ff ? device_address_field_ff : 7'h00;
			function_on           <= function_on_ff;
			configured_flag       <= configured_ff;
			endpoint_select_field <= epsel_ff;
			usb_irq               <= |(flags_ff & enables_ff);
		end
	end
endmodule : ugc_global_ctrl
`default_nettype wire

//--- rtl/ugc_line_sync.sv
// three-stage synchroniser for one bus line, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ugc_line_sync (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic line_in,
	input  wire logic rst_val,
	output var  logic line_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_ff    <= rst_val;
			s2_ff    <= rst_val;
			s3_ff    <= rst_val;
			line_out <= rst_val;
		end else begin
			s1_ff <= line_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				line_out <= s3_ff;
			end
		end
	end
endmodule : ugc_line_sync
`default_nettype wire

//--- rtl/ugc_pkg.sv
// package of offsets, fields, reset values and timing for the usb global control block
package ugc_pkg;
	// special-function register addresses
	localparam logic [7:0] UGC_ADDR_CONTROL  = 8'hbc;
	localparam logic [7:0] UGC_ADDR_FLAGS    = 8'hbd;
	localparam logic [7:0] UGC_ADDR_ENABLES  = 8'hbe;
	localparam logic [7:0] UGC_ADDR_FUNCADDR = 8'hc6;
	localparam logic [7:0] UGC_ADDR_EPSEL    = 8'hc7;
	// global control fields
	localparam int UGC_CTL_ADDR_VALID  = 0;
	localparam int UGC_CTL_CONFIGURED  = 1;
	localparam int UGC_CTL_WAKE_ALLOW  = 2;
	localparam int UGC_CTL_RESUME_PROG = 3;
	localparam int UGC_CTL_WAKE_REQ    = 5;
	// flag and enable fields
	localparam int UGC_FLG_SUSPEND     = 0;
	localparam int UGC_FLG_FRAME_START = 3;
	localparam int UGC_FLG_RESET_END   = 4;
	localparam int UGC_FLG_BUS_WAKE    = 5;
	// function address fields
	localparam int UGC_FA_FUNCTION_ON  = 7;
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] UGC_CTL_WMASK   = 8'h27;
	localparam logic [7:0] UGC_FLG_MASK    = 8'h39;
	localparam logic [7:0] UGC_EPSEL_MASK  = 8'h03;
	// reset values
	localparam logic [7:0] UGC_ENABLES_RST  = 8'h10;
	localparam logic [7:0] UGC_FUNCADDR_RST = 8'h00;
	localparam logic [7:0] UGC_ZERO_RST     = 8'h00;
	// timing
	localparam int UGC_CLK_MHZ        = 200;
	localparam int UGC_BUS_RESET_NS   = 2700;
	localparam int UGC_BUS_RESET_CYC  = (UGC_BUS_RESET_NS * UGC_CLK_MHZ + 999) / 1000;
	localparam int UGC_SUSPEND_MS     = 3;
	localparam int UGC_SUSPEND_CYC    = UGC_SUSPEND_MS * UGC_CLK_MHZ * 1000;
	localparam int UGC_SUSP_MIN_MS    = 5;
	localparam int UGC_SUSP_MIN_CYC   = UGC_SUSP_MIN_MS * UGC_CLK_MHZ * 1000;
	localparam int UGC_RESUME_MS      = 10;
	localparam int UGC_RESUME_CYC     = UGC_RESUME_MS * UGC_CLK_MHZ * 1000;
	localparam int UGC_CNT_W          = 24;
endpackage : ugc_pkg
